// *** core/periph_ctl_defs.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef PERIPH_CTL_DEFS_SVH
`define PERIPH_CTL_DEFS_SVH
`define OFF_PRESENT      8'h00
`define OFF_RUN_EN       8'h04
`define OFF_SLEEP_EN     8'h08
`define OFF_SW_RESET     8'h0C
`define OFF_GATING       8'h10
`define OFF_ACTIVE       8'h14
`define OFF_RST_BUSY     8'h18
`define GATING_BIT       0
`define RUN_EN_RESET     32'h0000_0000
`define SLEEP_EN_RESET   32'hFFFF_FFFF
`define ENABLE_DELAY     5
`define RESET_PULSE      4
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// *** core/periph_ctl_pkg.sv ***
// Types shared by the peripheral clock and reset control block.
package periph_ctl_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic        valid;
    } addr_chan_t;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
        logic        valid;
    } wdata_chan_t;
    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
        logic        valid;
    } rdata_chan_t;
    typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_t;
endpackage

// *** core/periph_clock_reset_gating.sv ***
// Per-peripheral presence, reset pulse and sleep clock gating control.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctl_defs.svh"
module periph_clock_reset_gating #(
    parameter int                 N_PERIPH = 32,
    parameter logic [N_PERIPH-1:0] PRESENT_MASK = '1
) (
    input  wire logic                      mclk_in,
    input  wire logic                      reset_in,
    input  wire logic                      clk_en_in,
    input  wire logic                      sleep_in,
    input  wire logic [7:0]                s_axi_awaddr_in,
    input  wire logic                      s_axi_awvalid_in,
    output logic                           s_axi_awready_out,
    input  wire logic [31:0]               s_axi_wdata_in,
    input  wire logic [3:0]                s_axi_wstrb_in,
    input  wire logic                      s_axi_wvalid_in,
    output logic                           s_axi_wready_out,
    output logic [1:0]                     s_axi_bresp_out,
    output logic                           s_axi_bvalid_out,
    input  wire logic                      s_axi_bready_in,
    input  wire logic [7:0]                s_axi_araddr_in,
    input  wire logic                      s_axi_arvalid_in,
    output logic                           s_axi_arready_out,
    output logic [31:0]                    s_axi_rdata_out,
    output logic [1:0]                     s_axi_rresp_out,
    output logic                           s_axi_rvalid_out,
    input  wire logic                      s_axi_rready_in,
    input  wire logic [N_PERIPH-1:0]       periph_access_in,
    output logic [N_PERIPH-1:0]            periph_fault_out,
    output logic [N_PERIPH-1:0]            periph_clk_en_out,
    output logic [N_PERIPH-1:0]            periph_reset_out
);
    import periph_ctl_pkg::*;

    localparam int CW = $clog2(`ENABLE_DELAY + 1);
    localparam int RW = $clog2(`RESET_PULSE + 1);

    addr_chan_t              aw_r;
    wdata_chan_t             w_r;
    rdata_chan_t             rd_r;
    wr_state_t               wst_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic [N_PERIPH-1:0]     run_en_r;
    logic [N_PERIPH-1:0]     sleep_en_r;
    logic                    gating_r;
    logic [N_PERIPH-1:0]     active_r;
    logic [N_PERIPH-1:0]     rst_busy_r;
    logic [N_PERIPH-1:0]     rst_req;
    logic                    wr_go;
    logic [31:0]             wmask;
    logic [31:0]             rd_nxt;
    logic                    rd_err_nxt;
    logic                    wr_err;
    logic [CW-1:0]           en_cnt_r [N_PERIPH];
    logic [RW-1:0]           rs_cnt_r [N_PERIPH];

    // Address and data are captured independently, so either may come first.
    // Readies drop while frozen, so no address or write-data handshake is seen that is not taken.
    assign s_axi_awready_out = clk_en_in && !aw_r.valid && wst_r == W_IDLE;
    assign s_axi_wready_out  = clk_en_in && !w_r.valid && wst_r == W_IDLE;
    assign s_axi_bvalid_out  = bvalid_r;
    assign s_axi_bresp_out   = bresp_r;
    assign s_axi_arready_out = clk_en_in && !rd_r.valid;
    assign s_axi_rvalid_out  = rd_r.valid;
    assign s_axi_rdata_out   = rd_r.data;
    assign s_axi_rresp_out   = rd_r.resp;
    assign wr_go = aw_r.valid && w_r.valid && wst_r == W_IDLE;

    // Byte strobes widened to a bit mask for the writable registers.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_r.strb[i]}};
        end
    end

    assign wr_err = !(aw_r.addr == `OFF_RUN_EN || aw_r.addr == `OFF_SLEEP_EN ||
                      aw_r.addr == `OFF_SW_RESET || aw_r.addr == `OFF_GATING);
    assign rst_req = (wr_go && aw_r.addr == `OFF_SW_RESET) ?
                     (w_r.data[N_PERIPH-1:0] & wmask[N_PERIPH-1:0]) : '0;

    // Write channel: capture, commit, respond.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            aw_r     <= '0;
            w_r      <= '0;
            wst_r    <= W_IDLE;
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (clk_en_in) begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_r <= '{addr: s_axi_awaddr_in, valid: 1'b1};
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_r <= '{data: s_axi_wdata_in, strb: s_axi_wstrb_in,
                         valid: 1'b1};
            end
            case (wst_r)
                W_IDLE: begin
                    if (wr_go) begin
                        bvalid_r <= 1'b1;
                        bresp_r  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
                        wst_r    <= W_RESP;
                    end
                end
                W_RESP: begin
                    if (s_axi_bready_in) begin
                        bvalid_r <= 1'b0;
                        aw_r     <= '0;
                        w_r      <= '0;
                        wst_r    <= W_IDLE;
                    end
                end
                default: wst_r <= W_IDLE;
            endcase
        end
    end

    // Control registers; reset writes never touch the enables.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            run_en_r   <= N_PERIPH'(`RUN_EN_RESET);
            sleep_en_r <= N_PERIPH'(`SLEEP_EN_RESET);
            gating_r   <= 1'b0;
        end else if (clk_en_in && wr_go) begin
            case (aw_r.addr)
                `OFF_RUN_EN: run_en_r <= (run_en_r & ~wmask[N_PERIPH-1:0]) |
                    (w_r.data[N_PERIPH-1:0] & wmask[N_PERIPH-1:0]);
                `OFF_SLEEP_EN: sleep_en_r <=
                    (sleep_en_r & ~wmask[N_PERIPH-1:0]) |
                    (w_r.data[N_PERIPH-1:0] & wmask[N_PERIPH-1:0]);
                `OFF_GATING: if (w_r.strb[0]) begin
                    gating_r <= w_r.data[`GATING_BIT];
                end
                default: ;
            endcase
        end
    end

    // Read mux; absent peripherals show zero in the presence, active and busy views, but not in the run and sleep enables.
    always_comb begin
        rd_nxt     = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        case (s_axi_araddr_in)
            `OFF_PRESENT:  rd_nxt[N_PERIPH-1:0] = PRESENT_MASK;
            `OFF_RUN_EN:   rd_nxt[N_PERIPH-1:0] = run_en_r;
            `OFF_SLEEP_EN: rd_nxt[N_PERIPH-1:0] = sleep_en_r;
            `OFF_SW_RESET: rd_nxt = 32'h0000_0000;
            `OFF_GATING:   rd_nxt[`GATING_BIT] = gating_r;
            `OFF_ACTIVE:   rd_nxt[N_PERIPH-1:0] = active_r;
            `OFF_RST_BUSY: rd_nxt[N_PERIPH-1:0] = rst_busy_r;
            default:       rd_err_nxt = 1'b1;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rd_r <= '0;
        end else if (clk_en_in) begin
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                rd_r <= '{data: rd_nxt,
                          resp: rd_err_nxt ? `RESP_SLVERR : `RESP_OKAY,
                          valid: 1'b1};
            end else if (rd_r.valid && s_axi_rready_in) begin
                rd_r.valid <= 1'b0;
            end
        end
    end

    // Per-peripheral enable delay and reset pulse counters.
    for (genvar p = 0; p < N_PERIPH; p++) begin : g_per
        // A peripheral is active only after the enable settles for a while.
        always_ff @(posedge mclk_in) begin
            if (reset_in) begin
                en_cnt_r[p] <= '0;
                active_r[p] <= 1'b0;
            end else if (clk_en_in) begin
                if (!run_en_r[p] || !PRESENT_MASK[p]) begin
                    en_cnt_r[p] <= '0;
                    active_r[p] <= 1'b0;
                end else if (en_cnt_r[p] != CW'(`ENABLE_DELAY - 1)) begin
                    en_cnt_r[p] <= en_cnt_r[p] + 1'b1;
                end else begin
                    active_r[p] <= 1'b1;
                end
            end
        end

        // Fixed-length pulse; a new request while busy restarts it.
        always_ff @(posedge mclk_in) begin
            if (reset_in) begin
                rs_cnt_r[p]   <= '0;
                rst_busy_r[p] <= 1'b0;
            end else if (clk_en_in) begin
                if (rst_req[p] && PRESENT_MASK[p]) begin
                    rs_cnt_r[p]   <= RW'(`RESET_PULSE);
                    rst_busy_r[p] <= 1'b1;
                end else if (rs_cnt_r[p] != '0) begin
                    rs_cnt_r[p]   <= rs_cnt_r[p] - 1'b1;
                    rst_busy_r[p] <= rs_cnt_r[p] != RW'(1);
                end
            end
        end
    end

    // Outputs: gated clock never touches reset, so state is kept in sleep.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            periph_clk_en_out <= '0;
            periph_reset_out  <= '1;
            periph_fault_out  <= '0;
        end else if (clk_en_in) begin
            periph_clk_en_out <= active_r &
                ~({N_PERIPH{sleep_in && gating_r}} & ~sleep_en_r);
            periph_reset_out  <= rst_busy_r | ~active_r;
            periph_fault_out  <= periph_access_in & ~active_r;
        end
    end
endmodule
`default_nettype wire

// *** testbench/periph_ctl_properties.sv ***
// Port-level assertions for the peripheral clock and reset control block.
`timescale 1ns/1ps
`default_nettype none
module periph_ctl_properties #(
    parameter int                  N_PERIPH     = 32,
    parameter logic [N_PERIPH-1:0] PRESENT_MASK = '1
) (
    input wire logic                mclk_in,
    input wire logic                reset_in,
    input wire logic                clk_en_in,
    input wire logic                s_axi_awvalid_in,
    input wire logic                s_axi_awready_out,
    input wire logic                s_axi_wvalid_in,
    input wire logic                s_axi_wready_out,
    input wire logic                s_axi_bvalid_out,
    input wire logic                s_axi_bready_in,
    input wire logic                s_axi_arvalid_in,
    input wire logic                s_axi_arready_out,
    input wire logic                s_axi_rvalid_out,
    input wire logic                s_axi_rready_in,
    input wire logic [31:0]         s_axi_rdata_out,
    input wire logic [N_PERIPH-1:0] periph_access_in,
    input wire logic [N_PERIPH-1:0] periph_fault_out,
    input wire logic [N_PERIPH-1:0] periph_clk_en_out,
    input wire logic [N_PERIPH-1:0] periph_reset_out
);
    // Everything lives in the system clock domain.
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    chk_write_answer: assert property (clk_en_in && s_axi_awvalid_in &&
        s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |-> ##2 s_axi_bvalid_out) else $error("write not answered");
    chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out) else $error("write answer dropped");
    chk_read_answer: assert property (clk_en_in && s_axi_arvalid_in &&
        s_axi_arready_out |=> s_axi_rvalid_out) else $error("read late");
    chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data not held");
    chk_ar_blocked: assert property (s_axi_rvalid_out |->
        !s_axi_arready_out) else $error("read accepted while busy");
    chk_reset_values: assert property ($fell(reset_in) && $past(clk_en_in)
        |-> (&periph_reset_out) && !(|periph_clk_en_out) && !s_axi_bvalid_out)
        else $error("bad state after reset");
    chk_absent_quiet: assert property ((periph_clk_en_out & ~PRESENT_MASK)
        == '0) else $error("absent peripheral clocked");
    chk_fault_cause: assert property ($past(clk_en_in) |->
        (periph_fault_out & ~$past(periph_access_in)) == '0)
        else $error("fault without access");
    cov_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
    cov_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
    cov_fault: cover property (|periph_fault_out);
endmodule
bind periph_clock_reset_gating periph_ctl_properties #(
    .N_PERIPH(N_PERIPH), .PRESENT_MASK(PRESENT_MASK)) u_props (.*);
`default_nettype wire

// *** testbench/periph_clock_reset_gating_tb.sv ***
// Self-checking bench for the peripheral clock and reset control block.
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctl_defs.svh"
module periph_clock_reset_gating_tb;
    import periph_ctl_pkg::*;
    localparam int           N  = 4;
    localparam logic [N-1:0] PM = 4'hB; // Peripheral 2 is absent.
    logic         mclk_in = 0, reset_in = 1, clk_en_in = 1, sleep_in = 0;
    logic [7:0]   s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
    logic         s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
    logic         s_axi_bready_in = 0, s_axi_arvalid_in = 0;
    logic         s_axi_rready_in = 0;
    logic [31:0]  s_axi_wdata_in = '0, s_axi_rdata_out;
    logic [3:0]   s_axi_wstrb_in = 4'hF;
    logic         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic         s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]   s_axi_bresp_out, s_axi_rresp_out;
    logic [N-1:0] periph_access_in = '0, periph_fault_out;
    logic [N-1:0] periph_clk_en_out, periph_reset_out;
    int           error_cnt = 0, num_checks = 0, cyc = 0;
    periph_clock_reset_gating #(.N_PERIPH(N), .PRESENT_MASK(PM)) dut (.*);
    // Free-running clock; the cycle ceiling is far above the ~100 needed.
    initial forever #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic at_neg(input int k);
        repeat (k) @(negedge mclk_in);
    endtask
    // Handshakes are judged at the falling edge, so the master sees settled
    // ready levels and still releases only after the rising edge.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic aw, w, b;
        @(posedge mclk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= 1;
        do begin
            at_neg(1);
            aw = s_axi_awvalid_in && s_axi_awready_out;
            w = s_axi_wvalid_in && s_axi_wready_out;
            b = s_axi_bvalid_out;
            if (b) chk(32'(s_axi_bresp_out), 32'(er));
            @(posedge mclk_in);
            if (aw) s_axi_awvalid_in <= 0;
            if (w) s_axi_wvalid_in <= 0;
        end while (!b);
        s_axi_bready_in <= 0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [31:0] m, input logic [1:0] er);
        logic ar, r;
        @(posedge mclk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= 1;
        do begin
            at_neg(1);
            ar = s_axi_arvalid_in && s_axi_arready_out;
            r = s_axi_rvalid_out;
            if (r) chk(s_axi_rdata_out & m, ed);
            if (r) chk(32'(s_axi_rresp_out), 32'(er));
            @(posedge mclk_in);
            if (ar) s_axi_arvalid_in <= 0;
        end while (!r);
        s_axi_rready_in <= 0;
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence: reset state, presence, enable delay, reset, sleep.
    initial begin
        int n;
        repeat (3) @(posedge mclk_in);
        reset_in <= 0;
        at_neg(1);
        chk(32'(periph_clk_en_out), 32'h0);
        chk(32'(periph_reset_out), 32'hF);
        axi_rd(`OFF_PRESENT, 32'hB, '1, `RESP_OKAY);
        axi_rd(`OFF_RUN_EN, 32'h0, '1, `RESP_OKAY);
        axi_rd(8'h40, 32'h0, 32'h0, `RESP_SLVERR);
        axi_wr(`OFF_PRESENT, 32'h0, `RESP_SLVERR);
        axi_rd(`OFF_PRESENT, 32'hB, '1, `RESP_OKAY);
        @(posedge mclk_in) periph_access_in <= 4'h1;
        at_neg(2);
        chk(32'(periph_fault_out), 32'h1);
        axi_wr(`OFF_RUN_EN, 32'hF, `RESP_OKAY);
        at_neg(1);
        chk(32'(periph_fault_out), 32'h1);
        at_neg(2);
        chk(32'(periph_fault_out), 32'h1);
        at_neg(8);
        chk(32'(periph_fault_out), 32'h0);
        chk(32'(periph_clk_en_out), 32'hB);
        chk(32'(periph_reset_out & PM), 32'h0);
        axi_wr(`OFF_SW_RESET, 32'h2, `RESP_OKAY);
        n = 0;
        repeat (12) begin
            at_neg(1);
            n += int'(periph_reset_out[1]);
            chk(32'(periph_reset_out & 4'h9), 32'h0);
        end
        chk(32'(n inside {[1:8]}), 32'h1);
        chk(32'(periph_clk_en_out), 32'hB);
        axi_rd(`OFF_RUN_EN, 32'hB, 32'hB, `RESP_OKAY);
        axi_wr(`OFF_SLEEP_EN, 32'h1, `RESP_OKAY);
        @(posedge mclk_in) sleep_in <= 1;
        at_neg(3);
        chk(32'(periph_clk_en_out), 32'hB);
        axi_wr(`OFF_GATING, 32'h1, `RESP_OKAY);
        at_neg(3);
        chk(32'(periph_clk_en_out), 32'h1);
        chk(32'(periph_reset_out & PM), 32'h0);
        @(posedge mclk_in) sleep_in <= 0;
        at_neg(3);
        chk(32'(periph_clk_en_out), 32'hB);
        axi_rd(`OFF_SLEEP_EN, 32'h1, 32'hF, `RESP_OKAY);
        // Frozen block must ignore sleep entry and refuse bus requests.
        @(posedge mclk_in) clk_en_in <= 0;
        @(posedge mclk_in) sleep_in <= 1;
        at_neg(3);
        chk(32'(periph_clk_en_out), 32'hB);
        chk(32'({s_axi_awready_out, s_axi_arready_out}), 32'h0);
        @(posedge mclk_in) clk_en_in <= 1;
        at_neg(2);
        chk(32'(periph_clk_en_out), 32'h1);
        // A reset in mid-run brings every peripheral back to disabled.
        @(posedge mclk_in) sleep_in <= 0;
        reset_in <= 1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 0;
        at_neg(1);
        chk(32'(periph_clk_en_out), 32'h0);
        chk(32'(periph_reset_out), 32'hF);
        axi_rd(`OFF_RUN_EN, 32'h0, '1, `RESP_OKAY);
        axi_rd(`OFF_GATING, 32'h0, '1, `RESP_OKAY);
        tally_and_finish();
    end
endmodule
`default_nettype wire
